/* ic_pkg.sv */
/*
 * ic_pkg: constants, codes and types shared by the interval counter channel.
 * Assumes one 125 MHz system clock; the count clock arrives as a plain sampled input.
 */
`default_nettype none
package ic_pkg;

    // ****************************************************************
    // modes and byte access codes
    // ****************************************************************
    localparam logic [2:0] MODE_TERM   = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE   = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SWSTB  = 3'h4;
    localparam logic [2:0] MODE_HWSTB  = 3'h5;

    localparam logic [1:0] RW_LATCH    = 2'h0;
    localparam logic [1:0] RW_LSB      = 2'h1;
    localparam logic [1:0] RW_MSB      = 2'h2;
    localparam logic [1:0] RW_BOTH     = 2'h3;

    // ****************************************************************
    // count element values and reset values
    // ****************************************************************
    localparam logic [16:0] CE_BIG     = 17'h10000;
    localparam logic [15:0] MAX_BIN    = 16'hffff;
    localparam logic [15:0] MAX_BCD    = 16'h9999;
    localparam logic [16:0] CE_ONE     = 17'h00001;
    localparam logic [16:0] CE_TWO     = 17'h00002;
    localparam logic [16:0] CE_ZERO    = 17'h00000;
    localparam logic [15:0] CR_RST     = 16'h0000;
    localparam logic [2:0]  MODE_RST   = 3'h0;
    localparam logic [1:0]  RW_RST     = 2'h3;
    localparam logic        OUT_RST    = 1'b1;

    typedef enum logic [2:0]
    {
        ST_WAIT  = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN   = 3'b100
    } ic_st_t;

endpackage : ic_pkg
`default_nettype wire

/* ic_dec_if.sv */
/*
 * ic_dec_if: carries the count element to the decrement unit and its next value back.
 * Assumes both ends sit in the same clock domain; the path is purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none
interface ic_dec_if;
    logic [16:0] cur;
    logic        step2;
    logic        bcd;
    logic [16:0] nxt;

    modport user (output cur, output step2, output bcd, input nxt);
    modport calc (input cur, input step2, input bcd, output nxt);
endinterface : ic_dec_if
`default_nettype wire

/* ic_dec.sv */
/*
 * ic_dec: subtracts one or two from the count element in binary or decimal coding.
 * Assumes bit 16 of the element marks the largest count, read as 65536 or 10000.
 */
`timescale 1ns/100ps
`default_nettype none
module ic_dec
    import ic_pkg::*;
(
    ic_dec_if.calc dp
);

    // ****************************************************************
    // operand selection
    // ****************************************************************
    logic [15:0] src;
    logic [1:0]  sub;
    logic [15:0] bin_res;
    logic [15:0] bcd_res;
    logic [4:0]  brw;

    // largest count: start from the top value and take one less
    assign src = dp.cur[16] ? (dp.bcd ? MAX_BCD : MAX_BIN) : dp.cur[15:0];
    assign sub = dp.cur[16] ? {1'b0, dp.step2} : (dp.step2 ? 2'h2 : 2'h1);
    assign bin_res = src - {14'h0000, sub};

    // ****************************************************************
    // decimal digits, borrow ripples upward
    // ****************************************************************
    assign brw[0] = 1'b0;
    genvar d;
    generate
        for (d = 0; d < 4; d++)
        begin : g_dig
            logic [4:0] diff;
            logic [1:0] take;
            assign take = (d == 0) ? sub : {1'b0, brw[d]};
            assign diff = {1'b0, src[4*d +: 4]} - {3'h0, take};
            assign brw[d+1] = diff[4];
            assign bcd_res[4*d +: 4] = diff[4] ? 4'(diff[3:0] + 4'ha) : diff[3:0];
        end
    endgenerate

    // wraps to the top value rather than stopping at zero
    assign dp.nxt = {1'b0, dp.bcd ? bcd_res : bin_res};

endmodule : ic_dec
`default_nettype wire

/* ic_counter.sv */
/*
 * ic_counter: one 16-bit down-counter channel with six counting modes.
 * Assumes host strobes and the count clock and gate are synchronous to ref_clk,
 * and that the count clock is much slower than ref_clk.
 */
// Behaviour
// - square wave, even count: output starts high, step two, toggle and reload
// - square wave, odd count: load count minus one, extra pulse before going low
// - odd square wave: high (N+1)/2 pulses, low (N-1)/2 pulses
// - software strobe: output high, one pulse low at expiry, count write starts
// - software strobe: gate high counts, gate low halts, never touches output
// - software strobe: load pulse does not decrement, strobe N+1 pulses later
// - software strobe: rewrite loads next pulse; first of two bytes has no effect
// - hardware strobe: load on pulse after gate rise, strobe N+1 pulses later
// - hardware strobe: each gate rise reloads; gate level leaves output alone
// - hardware strobe: new count waits for a trigger, running sequence untouched
// - control word write resets control logic and sets output initial state
// - gate sampled on count clock rise; level gates counting in modes 0,2,3,4
// - gate rise sets a capture flag, sampled at clock rise then cleared
// - loading and decrementing happen on count clock falling edges
// - initial count zero means 65536 binary or 10000 decimal
// - modes 0,1,4,5 wrap at zero to FFFF or 9999 and keep counting
// - modes 2 and 3 reload the initial count every cycle
// - trigger is gate rise; clock pulse is count clock rise then fall
`timescale 1ns/100ps
`default_nettype none
module ic_counter
(
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire logic           ctrl_wr,
    input  wire logic [2:0]     ctrl_mode,
    input  wire logic [1:0]     ctrl_rw,
    input  wire logic           ctrl_bcd,
    input  wire logic           cnt_wr,
    input  wire logic [7:0]     cnt_byte,
    input  wire logic           cnt_clk,
    input  wire logic           gate,
    output logic                cnt_out,
    output logic [15:0]         cur_count,
    output logic                running
);
    import ic_pkg::*;

    // ****************************************************************
    // programming registers
    // ****************************************************************
    logic [2:0]  mode_r;
    logic [1:0]  rw_r;
    logic        bcd_r;
    logic [15:0] cr_r;
    logic        lsb_done_r;
    logic        wr_done;
    logic        cw_take;
    logic [2:0]  mode_in;

    // modes 6 and 7 behave as 2 and 3; a latch command is not a control word
    assign mode_in = ctrl_mode[1] ? {1'b0, ctrl_mode[1:0]} : ctrl_mode;
    assign cw_take = ctrl_wr && (ctrl_rw != RW_LATCH);
    assign wr_done = cnt_wr && ((rw_r != RW_BOTH) || lsb_done_r);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r     <= MODE_RST;
            rw_r       <= RW_RST;
            bcd_r      <= 1'b0;
            cr_r       <= CR_RST;
            lsb_done_r <= 1'b0;
        end
        else if (cw_take)
        begin
            mode_r     <= mode_in;
            rw_r       <= ctrl_rw;
            bcd_r      <= ctrl_bcd;
            lsb_done_r <= 1'b0;
        end
        else if (cnt_wr)
        begin
            unique case (rw_r)
                RW_LSB:  cr_r <= {8'h00, cnt_byte};
                RW_MSB:  cr_r <= {cnt_byte, 8'h00};
                default:
                begin
                    // first byte only parks in the low half
                    if (lsb_done_r)
                        cr_r[15:8] <= cnt_byte;
                    else
                        cr_r[7:0] <= cnt_byte;
                    lsb_done_r <= !lsb_done_r;
                end
            endcase
        end
    end

    // ****************************************************************
    // count clock edges, gate sampling and trigger capture
    // ****************************************************************
    logic cclk_q;
    logic gate_q;
    logic cc_rise;
    logic cc_fall;
    logic gate_smp_r;
    logic trig_flag_r;
    logic trig_smp_r;

    assign cc_rise = cnt_clk && !cclk_q;
    assign cc_fall = !cnt_clk && cclk_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cclk_q     <= 1'b0;
            gate_q     <= 1'b1;  // a gate held high through reset is no trigger
            gate_smp_r <= 1'b0;
            trig_smp_r <= 1'b0;
        end
        else
        begin
            cclk_q <= cnt_clk;
            gate_q <= gate;
            if (cc_rise)
            begin
                gate_smp_r <= gate;
                trig_smp_r <= trig_flag_r;
            end
        end
    end

    // a new edge in the sampling cycle survives the clear, so no trigger is lost
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            trig_flag_r <= 1'b0;
        else if (gate && !gate_q)
            trig_flag_r <= 1'b1;
        else if (cc_rise || cw_take)
            trig_flag_r <= 1'b0;
    end

    // ****************************************************************
    // count element
    // ****************************************************************
    ic_st_t      st_r;
    logic [16:0] ce_r;
    logic [16:0] load_val;
    logic        edge_mode;
    logic        trig_mode;
    logic        level_mode;
    logic        gate_en;
    logic        do_load;
    logic        periodic;
    logic        sq_odd;
    logic        dec_en;
    logic        strobed_r;
    ic_dec_if    dif ();

    assign edge_mode  = (mode_r == MODE_ONESHOT) || (mode_r == MODE_HWSTB);
    assign trig_mode  = edge_mode || periodic;
    assign periodic   = (mode_r == MODE_RATE) || (mode_r == MODE_SQUARE);
    assign level_mode = !edge_mode;
    assign sq_odd     = (mode_r == MODE_SQUARE) && cr_r[0];
    // counting halts on a low sampled gate in modes 0,2,3,4, or mid two-byte write in mode 0
    assign gate_en = (!level_mode || gate_smp_r) &&
                     !((mode_r == MODE_TERM) && lsb_done_r);
    // zero is the largest count; odd square counts drop their low bit
    assign load_val = (cr_r == CR_RST) ? CE_BIG :
                      {1'b0, cr_r[15:1], cr_r[0] && !sq_odd};
    assign do_load = cc_fall &&
                     (((st_r == ST_ARMED) && (!edge_mode || trig_smp_r)) ||
                      ((st_r == ST_RUN) && trig_mode && trig_smp_r));
    assign dec_en  = cc_fall && (st_r == ST_RUN) && gate_en && !do_load;

    assign dif.cur   = ce_r;
    assign dif.step2 = (mode_r == MODE_SQUARE);
    assign dif.bcd   = bcd_r;

    ic_dec u_dec
    (
        .dp (dif.calc)
    );

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ST_WAIT;
            ce_r <= CE_ZERO;
        end
        else if (cw_take)
            st_r <= ST_WAIT;
        else if (wr_done && (st_r == ST_WAIT || mode_r == MODE_TERM || mode_r == MODE_SWSTB))
            st_r <= ST_ARMED;
        else if (do_load)
        begin
            st_r <= ST_RUN;
            ce_r <= load_val;
        end
        else if (dec_en)
        begin
            unique case (mode_r)
                MODE_RATE:
                    ce_r <= (ce_r == CE_ONE) ? load_val : dif.nxt;
                MODE_SQUARE:
                begin
                    // odd count, high half: hold one extra pulse at zero
                    if (ce_r == CE_ZERO)
                        ce_r <= load_val;
                    else if (ce_r == CE_TWO)
                        ce_r <= (sq_odd && cnt_out) ? CE_ZERO : load_val;
                    else
                        ce_r <= dif.nxt;
                end
                default:
                    ce_r <= dif.nxt;
            endcase
        end
    end

    // ****************************************************************
    // output
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_out   <= OUT_RST;
            strobed_r <= 1'b0;
        end
        else if (cw_take)
        begin
            cnt_out   <= (mode_in != MODE_TERM);
            strobed_r <= 1'b0;
        end
        else if (cnt_wr && (mode_r == MODE_TERM))
            cnt_out <= 1'b0;
        else if (periodic && !gate)
            cnt_out <= 1'b1;
        else if (do_load)
        begin
            strobed_r <= 1'b0;
            cnt_out   <= (mode_r != MODE_ONESHOT) && (mode_r != MODE_TERM);
        end
        else if (cc_fall)
        begin
            unique case (mode_r)
                MODE_TERM, MODE_ONESHOT:
                    if (dec_en && dif.nxt == CE_ZERO)
                        cnt_out <= 1'b1;
                MODE_RATE:
                    if (dec_en)
                        cnt_out <= (ce_r == CE_ONE) || (dif.nxt != CE_ONE);
                MODE_SQUARE:
                    if (dec_en && ce_r == CE_ZERO)
                        cnt_out <= 1'b0;
                    else if (dec_en && ce_r == CE_TWO && !(sq_odd && cnt_out))
                        cnt_out <= !cnt_out;
                default:
                begin
                    // strobe is low exactly one pulse, only once per load
                    if (dec_en && !strobed_r && dif.nxt == CE_ZERO)
                    begin
                        cnt_out   <= 1'b0;
                        strobed_r <= 1'b1;
                    end
                    else
                        cnt_out <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_count <= CR_RST;
            running   <= 1'b0;
        end
        else
        begin
            cur_count <= ce_r[15:0];
            running   <= (st_r == ST_RUN);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ctrl_reset_a: assert property (cw_take |=> st_r == ST_WAIT &&
                                   cnt_out == ($past(mode_in) != MODE_TERM))
        else $error("control word did not reset the channel");
    gate_force_a: assert property (periodic && !gate && !cw_take |=> cnt_out)
        else $error("gate low did not force output high");
    strobe_width_a: assert property ((mode_r == MODE_SWSTB) && cc_fall && !cnt_out &&
                                     !cw_take && !do_load |=> cnt_out)
        else $error("software strobe longer than one pulse");
    load_no_dec_a: assert property (do_load && !cw_take && !wr_done |=>
                                    ce_r == $past(load_val) && st_r == ST_RUN)
        else $error("load pulse altered the loaded count");
    gate_halt_a: assert property ((mode_r == MODE_SWSTB) && cc_fall && !gate_smp_r &&
                                  !do_load && !cw_take |=> $stable(ce_r))
        else $error("count moved while gate low");
    trig_catch_a: assert property (gate && !gate_q |=> trig_flag_r)
        else $error("gate rise not captured");
    fall_only_a: assert property (!cc_fall && !cw_take |=> $stable(ce_r))
        else $error("count changed off a falling edge");
    // a control word in the same cycle keeps the count, so it is left out
    sq_step_a: assert property (dec_en && (mode_r == MODE_SQUARE) && !bcd_r &&
                                !cw_take && !ce_r[16] && ce_r > CE_TWO |=>
                                ce_r == $past(ce_r) - CE_TWO)
        else $error("square wave step is not two");
    hw_wait_a: assert property ((mode_r == MODE_HWSTB) && (st_r == ST_ARMED) &&
                                cc_fall && !trig_smp_r && !cw_take |=> st_r == ST_ARMED)
        else $error("hardware strobe loaded without trigger");
    // a count write in the same cycle re-arms instead of stepping
    wrap_a: assert property (dec_en && (mode_r == MODE_SWSTB) && !bcd_r &&
                             !cw_take && !wr_done && ce_r == CE_ZERO |=>
                             ce_r == {1'b0, MAX_BIN})
        else $error("counter did not wrap to top");

    sw_strobe_c: cover property ((mode_r == MODE_SWSTB) && $fell(cnt_out));
    hw_strobe_c: cover property ((mode_r == MODE_HWSTB) && $fell(cnt_out));
    sq_toggle_c: cover property ((mode_r == MODE_SQUARE) && sq_odd && $rose(cnt_out));

endmodule : ic_counter
`default_nettype wire

/* ic_host.sv */
/*
 * ic_host: host model that writes control words and count bytes to one channel.
 * Assumes the bench calls its tasks from one process and that ref_clk runs free.
 */
`timescale 1ns/100ps
`default_nettype none
module ic_host
    import ic_pkg::*;
(
    input  wire logic       ref_clk,
    output var  logic       ctrl_wr,
    output var  logic [2:0] ctrl_mode,
    output var  logic [1:0] ctrl_rw,
    output var  logic       ctrl_bcd,
    output var  logic       cnt_wr,
    output var  logic [7:0] cnt_byte
);
    // ****************************************************************
    // host write cycles
    // ****************************************************************
    logic [2:0] mode_r;
    logic [1:0] rw_r;

    initial
    begin
        ctrl_wr   = 1'b0;
        ctrl_mode = 3'h7;
        ctrl_rw   = 2'h0;
        ctrl_bcd  = 1'b0;
        cnt_wr    = 1'b0;
        cnt_byte  = 8'h5a;
        mode_r    = MODE_TERM;
        rw_r      = RW_BOTH;
    end

    // released lines show inverted data so a stale value is never mistaken for a write
    task automatic wr_ctrl(input logic [2:0] mode, input logic [1:0] rw, input logic bcd);
        @(posedge ref_clk);
        ctrl_wr   <= 1'b1;
        ctrl_mode <= mode;
        ctrl_rw   <= rw;
        ctrl_bcd  <= bcd;
        mode_r    = mode;
        rw_r      = rw;
        @(posedge ref_clk);
        ctrl_wr   <= 1'b0;
        ctrl_mode <= ~mode;
        ctrl_rw   <= ~rw;
        ctrl_bcd  <= ~bcd;
        @(posedge ref_clk);
    endtask : wr_ctrl

    task automatic wr_byte(input logic [7:0] b);
        @(posedge ref_clk);
        cnt_wr   <= 1'b1;
        cnt_byte <= b;
        @(posedge ref_clk);
        cnt_wr   <= 1'b0;
        cnt_byte <= ~b;
        @(posedge ref_clk);
    endtask : wr_byte

    task automatic wr_count(input logic [15:0] n);
        if (mode_r == MODE_RATE && n == 16'h0001)
            return;
        if (rw_r != RW_MSB)
            wr_byte(n[7:0]);
        if (rw_r != RW_LSB)
            wr_byte(n[15:8]);
    endtask : wr_count
endmodule : ic_host
`default_nettype wire

/* tb.sv */
/*
 * tb: self-checking bench for one interval counter channel in modes 3, 4 and 5.
 * Assumes the count clock is made here at one ninth of ref_clk or slower.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ic_pkg::*;

    // ****************************************************************
    // signals and instances
    // ****************************************************************
    logic        ref_clk, rst_n, cnt_clk, gate, ctrl_wr, ctrl_bcd, cnt_wr, cnt_out, running;
    logic [2:0]  ctrl_mode;
    logic [1:0]  ctrl_rw;
    logic [7:0]  cnt_byte;
    logic [15:0] cur_count, held;
    int          miscompares, n_checks, cycles;

    ic_counter ic_counter_i (.ref_clk(ref_clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
        .ctrl_mode(ctrl_mode), .ctrl_rw(ctrl_rw), .ctrl_bcd(ctrl_bcd), .cnt_wr(cnt_wr),
        .cnt_byte(cnt_byte), .cnt_clk(cnt_clk), .gate(gate), .cnt_out(cnt_out),
        .cur_count(cur_count), .running(running));

    ic_host ic_host_i (.ref_clk(ref_clk), .ctrl_wr(ctrl_wr), .ctrl_mode(ctrl_mode),
        .ctrl_rw(ctrl_rw), .ctrl_bcd(ctrl_bcd), .cnt_wr(cnt_wr), .cnt_byte(cnt_byte));

    always #4 ref_clk = ~ref_clk;

    // ****************************************************************
    // helper tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // each level held four ref cycles so the fall is seen and its result has landed
    task automatic pulse;
        @(posedge ref_clk);
        cnt_clk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cnt_clk <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : pulse

    // a one-cycle excursion of gate; the edge comes back before the next count clock rise
    task automatic trig;
        @(posedge ref_clk);
        gate <= !gate;
        @(posedge ref_clk);
        gate <= !gate;
    endtask : trig

    task automatic strobe(input int n, input int at);
        for (int k = 1; k <= n; k++)
        begin
            pulse();
            chk("strobe output", (k == at) ? 16'h0000 : 16'h0001, {15'h0000, cnt_out});
        end
    endtask : strobe

    task automatic square(input int n, input int len);
        int hi;
        hi = (n + 1) / 2;
        for (int k = 1; k <= len; k++)
        begin
            pulse();
            chk("square output", (((k - 1) % n) < hi) ? 16'h0001 : 16'h0000,
                {15'h0000, cnt_out});
        end
    endtask : square

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // ****************************************************************
    // timeout: the whole run needs well under a thousand cycles
    // ****************************************************************
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        ref_clk     = 1'b0;
        rst_n       = 1'b0;
        cnt_clk     = 1'b0;
        gate        = 1'b1;
        miscompares = 0;
        n_checks    = 0;
        cycles      = 0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        // software strobe, count of three, then wrap
        ic_host_i.wr_ctrl(MODE_SWSTB, RW_LSB, 1'b0);
        chk("initial output", 16'h0001, {15'h0000, cnt_out});
        ic_host_i.wr_count(16'h0003);
        strobe(8, 4);
        chk("wrapped count", 16'hfffc, cur_count);
        // gate low halts, then a two-byte rewrite during counting
        ic_host_i.wr_ctrl(MODE_SWSTB, RW_BOTH, 1'b0);
        ic_host_i.wr_count(16'h0005);
        strobe(2, 0);
        @(posedge ref_clk);
        gate <= 1'b0;
        strobe(3, 0);
        chk("halted count", 16'h0004, cur_count);
        @(posedge ref_clk);
        gate <= 1'b1;
        pulse();
        ic_host_i.wr_byte(8'h03);
        pulse();
        chk("count after first byte", 16'h0002, cur_count);
        ic_host_i.wr_byte(8'h00);
        strobe(4, 4);
        // decimal count of zero is the largest count
        ic_host_i.wr_ctrl(MODE_SWSTB, RW_BOTH, 1'b1);
        ic_host_i.wr_count(16'h0000);
        pulse();
        pulse();
        chk("decimal largest count", 16'h9999, cur_count);
        // high byte only, then a latch command that must leave the channel alone
        ic_host_i.wr_ctrl(MODE_SWSTB, RW_MSB, 1'b0);
        ic_host_i.wr_count(16'h0100);
        pulse();
        chk("high byte count", 16'h0100, cur_count);
        chk("running after load", 16'h0001, {15'h0000, running});
        ic_host_i.wr_ctrl(MODE_HWSTB, RW_LATCH, 1'b0);
        pulse();
        chk("count after latch command", 16'h00ff, cur_count);
        // hardware strobe: no load without a trigger, rewrite, retrigger
        @(posedge ref_clk);
        gate <= 1'b0;
        ic_host_i.wr_ctrl(MODE_HWSTB, RW_LSB, 1'b0);
        ic_host_i.wr_count(16'h0004);
        strobe(6, 0);
        chk("running before trigger", 16'h0000, {15'h0000, running});
        trig();
        strobe(3, 0);
        chk("running after trigger", 16'h0001, {15'h0000, running});
        ic_host_i.wr_count(16'h0002);
        strobe(3, 2);
        trig();
        strobe(2, 0);
        trig();
        strobe(4, 3);
        // square wave, even count, then a control word while output is low
        @(posedge ref_clk);
        gate <= 1'b1;
        ic_host_i.wr_ctrl(MODE_SQUARE, RW_LSB, 1'b0);
        ic_host_i.wr_count(16'h0004);
        trig();
        square(4, 8);
        ic_host_i.wr_ctrl(MODE_SQUARE, RW_LSB, 1'b0);
        chk("output after control word", 16'h0001, {15'h0000, cnt_out});
        // square wave, odd count, then gate low while output is low
        ic_host_i.wr_count(16'h0005);
        trig();
        square(5, 10);
        @(posedge ref_clk);
        gate <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("output on gate low", 16'h0001, {15'h0000, cnt_out});
        held = cur_count;
        pulse();
        chk("count with gate low", held, cur_count);
        conclude();
    end
endmodule : tb
`default_nettype wire
